// ---- inc/pf_cfg.svh ----
`ifndef PF_CFG_SVH
`define PF_CFG_SVH

// Register byte addresses
`define PF_ADDR_PINS   8'h00
`define PF_ADDR_LATCH  8'h04
`define PF_ADDR_DIR    8'h08
`define PF_ADDR_ANCFG  8'h0c
`define PF_ADDR_CMP    8'h10
`define PF_ADDR_CVR    8'h14

// Reset values
`define PF_RST_LATCH   8'h00
`define PF_RST_DIR     8'hff
`define PF_RST_ANCFG   8'h00
`define PF_RST_CMP     8'h07
`define PF_RST_CVR     8'h00

// Writable bits of the configuration registers
`define PF_ANCFG_WMASK 8'h3f
`define PF_CMP_WMASK   8'h3f

// Comparator modes
`define PF_CM_OFF      3'h7
`define PF_CM_OUT      3'h3

// Analog select decode: channel analog when channel + select <= limit
`define PF_CH_BASE     5'h05
`define PF_ANALOG_LIM  5'h0e

// Pin positions of the shared functions
`define PF_PIN_CMP2_OUT 1
`define PF_PIN_CMP1_OUT 2
`define PF_PIN_CMP2_P   3
`define PF_PIN_CMP2_N   4
`define PF_PIN_CMP1_P   5
`define PF_PIN_CMP1_N   6
`define PF_PIN_VREF     5
`define PF_PIN_SS       7
`define PF_NUM_ANALOG   7
`define PF_CMP_LO       1
`define PF_CMP_HI       6

// Bus responses
`define PF_RESP_OKAY   2'h0
`define PF_RESP_SLVERR 2'h2

`endif

// ---- inc/pf_pkg.sv ----
package pf_pkg;

    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] reference_select_bit;
        logic [3:0] analog_select_field;
    } pf_ancfg_type;

    typedef struct packed {
        logic       second_comparator_result;
        logic       first_comparator_result;
        logic       second_comparator_invert;
        logic       first_comparator_invert;
        logic       comparator_input_switch;
        logic [2:0] comparator_mode_field;
    } pf_cmp_type;

    typedef struct packed {
        logic       reference_enable_bit;
        logic       reference_output_enable_bit;
        logic       reference_range;
        logic       reference_source;
        logic [3:0] reference_value;
    } pf_cvr_type;

    typedef struct packed {
        logic [7:0]   port_output_latch;
        logic [7:0]   port_direction;
        pf_ancfg_type analog_pin_config;
        pf_cmp_type   comparator_control;
        pf_cvr_type   comparator_reference_control;
    } pf_regs_type;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe_n;
    } pf_pin_drive_type;

endpackage

// ---- verilog/pf_port.sv ----
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`include "pf_cfg.svh"

// Contract
// - An output pin with no peripheral override is driven from its latch bit, whether or not it is analog.
// - An input pin reads back its synchronised level on the port register unless analog, in bits 1 to 6 with comparators on, or bit 5 under reference output.
// - Port bits 0 to 6 are converter channels 5 to 11 and act as such only with their direction bit at 1.
// - After reset the analog-capable pins are analog inputs with their digital inputs off.
// - Comparator two takes bits 3 and 4 as inputs, comparator one takes bits 5 and 6.
// - With comparator two routed out and bit 1 an output, bit 1 drives the comparator two result.
// - With comparator one routed out and bit 2 an output, bit 2 drives the comparator one result.
// - An enabled reference output on bit 5 turns off both the digital driver and input of that pin.
// - Bit 7 is never analog and, as an input, feeds the serial port slave select.
// - Bit 0 and its latch and direction bits exist only in the largest package option.
// - Unimplemented register bits, analog configuration bits 7 and 6 among them, read as zero.
// - Direction 1 turns the pin driver off, direction 0 turns it on.
// - After any reset bits 6 to 0 are analog and read as zero on the port register.
module pf_port #(
    parameter bit HAS_BIT0 = 1'b1
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe_n,
    input  wire logic        first_comparator_result,
    input  wire logic        second_comparator_result,
    output logic [6:0]       converter_channel_enable,
    output logic [3:0]       comparator_input_enable,
    output logic [2:0]       comparator_mode_field,
    output logic             comparator_input_switch,
    output logic             comparator_reference_output,
    output logic             serial_slave_select_n
);

    // Bit 0 is absent in the smaller package options
    localparam logic [7:0] IMPL_MASK = HAS_BIT0 ? 8'hff : 8'hfe;

    pf_pkg::pf_regs_type regs_reg, regs_next;
    logic [7:0]  pin_meta_reg, pin_sync_reg;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic        aw_held_reg, aw_held_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        wbyte_reg, wbyte_next;
    logic        w_held_reg, w_held_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    logic [7:0]  analog_sel;
    logic [7:0]  dig_in_en;
    logic [7:0]  pin_read;
    logic        cmp_on;
    logic        cmp_out_routed;
    logic        vref_out;
    pf_pkg::pf_pin_drive_type drive;

    // Pins come from off chip: two flops before anything looks at them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign cmp_on         = regs_reg.comparator_control.comparator_mode_field != `PF_CM_OFF;
    assign cmp_out_routed = regs_reg.comparator_control.comparator_mode_field == `PF_CM_OUT;
    assign vref_out       = regs_reg.comparator_reference_control.reference_enable_bit
                          & regs_reg.comparator_reference_control.reference_output_enable_bit;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            // Analog decode: select 0 makes every channel analog, select 15 none
            if (gi < `PF_NUM_ANALOG) begin : g_ana
                assign analog_sel[gi] = (`PF_CH_BASE + 5'(gi)
                    + {1'b0, regs_reg.analog_pin_config.analog_select_field}) <= `PF_ANALOG_LIM;
            end else begin : g_dig
                assign analog_sel[gi] = 1'b0;
            end

            // Comparators hold their pins whenever they are on, so the digital input stays off too
            assign dig_in_en[gi] = IMPL_MASK[gi] & ~analog_sel[gi]
                & ~(cmp_on && gi >= `PF_CMP_LO && gi <= `PF_CMP_HI)
                & ~(vref_out && gi == `PF_PIN_VREF);
            assign pin_read[gi] = dig_in_en[gi] & pin_sync_reg[gi];

            always_comb begin
                drive.oe_n[gi]  = regs_reg.port_direction[gi] | ~IMPL_MASK[gi];
                drive.level[gi] = regs_reg.port_output_latch[gi] & IMPL_MASK[gi];
                if (vref_out && gi == `PF_PIN_VREF) begin
                    drive.oe_n[gi] = 1'b1;
                end
                if (cmp_out_routed && gi == `PF_PIN_CMP2_OUT) begin
                    drive.level[gi] = second_comparator_result;
                end
                if (cmp_out_routed && gi == `PF_PIN_CMP1_OUT) begin
                    drive.level[gi] = first_comparator_result;
                end
            end
        end
    endgenerate

    assign pin_out  = drive.level;
    assign pin_oe_n = drive.oe_n;

    // Channel 5 + i is live only with the pin set as an input
    assign converter_channel_enable = analog_sel[6:0] & regs_reg.port_direction[6:0] & IMPL_MASK[6:0];

    // Order: comparator two +, -, comparator one +, -
    assign comparator_input_enable = {4{cmp_on}} & {regs_reg.port_direction[`PF_PIN_CMP1_N],
                                                    regs_reg.port_direction[`PF_PIN_CMP1_P],
                                                    regs_reg.port_direction[`PF_PIN_CMP2_N],
                                                    regs_reg.port_direction[`PF_PIN_CMP2_P]};
    assign comparator_mode_field       = regs_reg.comparator_control.comparator_mode_field;
    assign comparator_input_switch     = regs_reg.comparator_control.comparator_input_switch;
    assign comparator_reference_output = vref_out;

    // Slave select idles high unless bit 7 is an input
    assign serial_slave_select_n = regs_reg.port_direction[`PF_PIN_SS] ? pin_sync_reg[`PF_PIN_SS] : 1'b1;

    // Bus handshakes
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    always_comb begin
        regs_next    = regs_reg;
        awaddr_next  = awaddr_reg;
        aw_held_next = aw_held_reg;
        wdata_next   = wdata_reg;
        wbyte_next   = wbyte_reg;
        w_held_next  = w_held_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;

        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_next  = s_axi_awaddr;
            aw_held_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_next  = s_axi_wdata[7:0];
            wbyte_next  = s_axi_wstrb[0];
            w_held_next = 1'b1;
        end

        // Commit one cycle after both halves are held
        if (aw_held_reg && w_held_reg) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `PF_RESP_OKAY;
            case (awaddr_reg)
                `PF_ADDR_PINS, `PF_ADDR_LATCH: begin
                    if (wbyte_reg) begin
                        regs_next.port_output_latch = wdata_reg & IMPL_MASK;
                    end
                end
                `PF_ADDR_DIR: begin
                    if (wbyte_reg) begin
                        regs_next.port_direction = wdata_reg | ~IMPL_MASK;
                    end
                end
                `PF_ADDR_ANCFG: begin
                    if (wbyte_reg) begin
                        regs_next.analog_pin_config = wdata_reg & `PF_ANCFG_WMASK;
                    end
                end
                `PF_ADDR_CMP: begin
                    if (wbyte_reg) begin
                        regs_next.comparator_control = wdata_reg & `PF_CMP_WMASK;
                    end
                end
                `PF_ADDR_CVR: begin
                    if (wbyte_reg) begin
                        regs_next.comparator_reference_control = wdata_reg;
                    end
                end
                default: begin
                    bresp_next = `PF_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = `PF_RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            case (s_axi_araddr)
                `PF_ADDR_PINS:  rdata_next[7:0] = pin_read;
                `PF_ADDR_LATCH: rdata_next[7:0] = regs_reg.port_output_latch;
                `PF_ADDR_DIR:   rdata_next[7:0] = regs_reg.port_direction & IMPL_MASK;
                `PF_ADDR_ANCFG: rdata_next[7:0] = regs_reg.analog_pin_config & `PF_ANCFG_WMASK;
                `PF_ADDR_CMP: begin
                    rdata_next[7:0] = {second_comparator_result, first_comparator_result,
                                       regs_reg.comparator_control[5:0]};
                end
                `PF_ADDR_CVR:   rdata_next[7:0] = regs_reg.comparator_reference_control;
                default:        rresp_next = `PF_RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_reg.port_output_latch            <= `PF_RST_LATCH;
            regs_reg.port_direction               <= `PF_RST_DIR;
            regs_reg.analog_pin_config            <= `PF_RST_ANCFG;
            regs_reg.comparator_control           <= `PF_RST_CMP;
            regs_reg.comparator_reference_control <= `PF_RST_CVR;
            awaddr_reg   <= 8'h00;
            aw_held_reg  <= 1'b0;
            wdata_reg    <= 8'h00;
            wbyte_reg    <= 1'b0;
            w_held_reg   <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= `PF_RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= `PF_RESP_OKAY;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            regs_reg    <= regs_next;
            awaddr_reg  <= awaddr_next;
            aw_held_reg <= aw_held_next;
            wdata_reg   <= wdata_next;
            wbyte_reg   <= wbyte_next;
            w_held_reg  <= w_held_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

endmodule

// ---- sim/pf_port_properties.sv ----
module pf_port_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic        first_comparator_result,
    input wire logic        second_comparator_result,
    input wire logic [6:0]  converter_channel_enable,
    input wire logic [3:0]  comparator_input_enable,
    input wire logic [2:0]  comparator_mode_field,
    input wire logic        comparator_reference_output,
    input wire logic        serial_slave_select_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst; $rose(aresetn) |-> pin_oe_n == 8'hff && converter_channel_enable == 7'h7f; endproperty
    a_rst: assert property (p_rst) else $error("pins not released or not analog after reset");
    // The commit edge sets bvalid, so it is first sampled high one edge later
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
    a_rd: assert property (p_rd) else $error("read late or upper bits set");
    property p_chan; (converter_channel_enable & ~pin_oe_n[6:0]) == 7'h0; endproperty
    a_chan: assert property (p_chan) else $error("channel enabled on an output pin");
    property p_cin;
        comparator_input_enable != 4'h0 |->
            comparator_mode_field != 3'h7 && (comparator_input_enable & ~pin_oe_n[6:3]) == 4'h0;
    endproperty
    a_cin: assert property (p_cin) else $error("comparator input on bad pin");
    property p_c2; comparator_mode_field == 3'h3 && !pin_oe_n[1] |-> pin_out[1] == second_comparator_result; endproperty
    a_c2: assert property (p_c2) else $error("bit 1 not showing comparator two");
    property p_c1; comparator_mode_field == 3'h3 && !pin_oe_n[2] |-> pin_out[2] == first_comparator_result; endproperty
    a_c1: assert property (p_c1) else $error("bit 2 not showing comparator one");
    property p_vref; comparator_reference_output |-> pin_oe_n[5]; endproperty
    a_vref: assert property (p_vref) else $error("bit 5 driven under reference");
    // Three stable edges cover the two synchroniser stages
    property p_ss; ($stable(pin_in[7]) && pin_oe_n[7])[*3] |-> serial_slave_select_n == pin_in[7]; endproperty
    a_ss: assert property (p_ss) else $error("slave select does not follow bit 7");
    c_wr: cover property (s_axi_bvalid);
    c_rd: cover property (s_axi_rvalid);
    c_cmp: cover property (comparator_mode_field == 3'h3 && !pin_oe_n[1]);
endmodule

bind pf_port pf_port_properties pf_port_properties_inst (.*);

// ---- sim/pf_pins_model.sv ----
module pf_pins_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] board_level,
    output logic [7:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // A driven pin shows the device level, a released one the board level
    assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule

// ---- sim/test_port_f_pin_mux_logic.sv ----
`include "pf_cfg.svh"
module test_port_f_pin_mux_logic;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        first_comparator_result, second_comparator_result, comparator_input_switch;
    logic        comparator_reference_output, serial_slave_select_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, board, pin_in, pin_out, pin_oe_n;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  converter_channel_enable;
    logic [3:0]  comparator_input_enable;
    logic [2:0]  comparator_mode_field;
    int          mismatches, total_checks;

    pf_port pf_port_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n, .first_comparator_result,
        .second_comparator_result, .converter_channel_enable, .comparator_input_enable, .comparator_mode_field,
        .comparator_input_switch, .comparator_reference_output, .serial_slave_select_n);
    pf_pins_model pf_pins_model_inst (.pin_out, .pin_oe_n, .board_level(board), .pin_in);

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic expire(input int n);
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 20);
        s_axi_bready <= 1'b0;
        expire(n);
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 20);
        s_axi_rready <= 1'b0;
        expire(n);
        chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
    endtask

    task automatic t_reset();
        rd(`PF_ADDR_LATCH, 8'h00, 2'h0);
        rd(`PF_ADDR_DIR, 8'hff, 2'h0);
        rd(`PF_ADDR_ANCFG, 8'h00, 2'h0);
        rd(`PF_ADDR_CMP, 8'h07, 2'h0);
        rd(`PF_ADDR_CVR, 8'h00, 2'h0);
        rd(`PF_ADDR_PINS, 8'h80, 2'h0);
        rd(8'h18, 8'h00, 2'h2);
        wr(8'h18, 8'hff, 2'h2);
        $display("test reset done");
    endtask
    task automatic t_out();
        wr(`PF_ADDR_DIR, 8'h00, 2'h0);
        wr(`PF_ADDR_PINS, 8'ha5, 2'h0);
        rd(`PF_ADDR_LATCH, 8'ha5, 2'h0);
        chk({pin_oe_n, pin_out}, 16'h00a5);
        rd(`PF_ADDR_PINS, 8'h80, 2'h0);
        $display("test output done");
    endtask
    task automatic t_in();
        board <= 8'h5a;
        wr(`PF_ADDR_DIR, 8'hff, 2'h0);
        wr(`PF_ADDR_ANCFG, 8'hff, 2'h0);
        rd(`PF_ADDR_ANCFG, 8'h3f, 2'h0);
        rd(`PF_ADDR_PINS, 8'h5a, 2'h0);
        wr(`PF_ADDR_ANCFG, 8'h05, 2'h0);
        chk(converter_channel_enable, 7'h1f);
        rd(`PF_ADDR_PINS, 8'h40, 2'h0);
        $display("test input done");
    endtask
    task automatic t_cmp();
        wr(`PF_ADDR_ANCFG, 8'h0f, 2'h0);
        wr(`PF_ADDR_DIR, 8'hf9, 2'h0);
        second_comparator_result <= 1'b1;
        wr(`PF_ADDR_CMP, 8'h03, 2'h0);
        chk({comparator_input_enable, pin_out[2:1]}, 6'h3d);
        chk({comparator_input_switch, comparator_mode_field}, 4'h3);
        rd(`PF_ADDR_CMP, 8'h83, 2'h0);
        rd(`PF_ADDR_PINS, 8'h00, 2'h0);
        first_comparator_result <= 1'b1;
        second_comparator_result <= 1'b0;
        @(negedge aclk);
        chk(pin_out[2:1], 2'h2);
        wr(`PF_ADDR_CMP, 8'h0b, 2'h0);
        chk({comparator_input_switch, comparator_mode_field}, 4'hb);
        // Comparators must go off as well before bits 6..1 read digitally
        wr(`PF_ADDR_CMP, 8'h07, 2'h0);
        rd(`PF_ADDR_PINS, 8'h5c, 2'h0);
        $display("test comparator done");
    endtask
    task automatic t_vref();
        wr(`PF_ADDR_DIR, 8'h00, 2'h0);
        wr(`PF_ADDR_CVR, 8'hc0, 2'h0);
        chk({comparator_reference_output, pin_oe_n}, 9'h120);
        rd(`PF_ADDR_PINS, 8'h85, 2'h0);
        wr(`PF_ADDR_CVR, 8'h00, 2'h0);
        $display("test reference done");
    endtask
    task automatic t_ss();
        board <= 8'h00;
        wr(`PF_ADDR_DIR, 8'hff, 2'h0);
        repeat (3) @(posedge aclk);
        chk(serial_slave_select_n, 1'b0);
        wr(`PF_ADDR_DIR, 8'h7f, 2'h0);
        chk(serial_slave_select_n, 1'b1);
        $display("test select done");
    endtask
    task automatic t_rerst();
        board <= 8'hff;
        wr(`PF_ADDR_ANCFG, 8'h0f, 2'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // First read gives the synchroniser time to refill
        rd(`PF_ADDR_ANCFG, 8'h00, 2'h0);
        chk({pin_oe_n, 1'b0, converter_channel_enable}, 16'hff7f);
        rd(`PF_ADDR_PINS, 8'h80, 2'h0);
        $display("test second reset done");
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {first_comparator_result, second_comparator_result} = 2'h0;
        board = 8'hff;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_out();
        t_in();
        t_cmp();
        t_vref();
        t_ss();
        t_rerst();
        summarize();
    end
endmodule
